// file: pkg/acr_pkg.sv
// acr_pkg: shared constants and types for the channel routing register bank.
// assumes a 24-bit serial frame: direction bit, 7 address bits, 16 data bits.
package acr_pkg;
  // register addresses, identical in master and channel banks where shared
  localparam logic [6:0] ADDR_CHAN_SEL    = 7'h01;
  localparam logic [6:0] ADDR_SRC_OVR     = 7'h16;
  localparam logic [6:0] ADDR_OFS_A       = 7'h17;
  localparam logic [6:0] ADDR_CM          = 7'h1B;
  localparam logic [6:0] ADDR_RIN         = 7'h1C;
  localparam logic [6:0] ADDR_CAL1        = 7'h33;
  localparam logic [6:0] ADDR_GAIN        = 7'h3A;
  localparam logic [6:0] ADDR_INT_GAIN    = 7'h3B;
  localparam logic [6:0] ADDR_PHASE       = 7'h3D;
  localparam logic [6:0] ADDR_CAL1_RO     = 7'h4F;
  localparam logic [6:0] ADDR_GAIN_RO     = 7'h56;
  localparam logic [6:0] ADDR_INT_GAIN_RO = 7'h57;
  localparam logic [6:0] ADDR_PHASE_RO    = 7'h59;
  localparam logic [6:0] ADDR_STANDBY     = 7'h5C;
  // channel selection codes
  localparam logic [2:0] SEL_ALL          = 3'h4;
  localparam logic [2:0] SEL_MASTER       = 3'h7;
  localparam logic [2:0] CHAN_SEL_RST     = 3'h4;
  // override field layout
  localparam logic [15:0] CH_OVR_MASK     = 16'h01D0;
  localparam int         MOVR_OFS         = 0;
  localparam int         MOVR_CM          = 1;
  localparam int         MOVR_RIN         = 2;
  localparam int         COVR_PHASE       = 4;
  localparam int         COVR_INT_GAIN    = 6;
  localparam int         COVR_GAIN        = 7;
  localparam int         COVR_CAL         = 8;
  // reset values
  localparam logic [2:0]  MST_OVR_RST     = 3'h0;
  localparam logic [15:0] CH_OVR_RST      = 16'h0000;
  localparam logic [8:0]  OFS_RST         = 9'h100;
  localparam logic [4:0]  CM_RST          = 5'h10;
  localparam logic [3:0]  RIN_RST         = 4'h8;
  localparam logic [6:0]  CAL_RST         = 7'h40;
  localparam logic [9:0]  GAIN_RST        = 10'h200;
  localparam logic [7:0]  INT_GAIN_RST    = 8'h80;
  localparam logic [7:0]  PHASE_RST       = 8'h80;
  localparam logic [4:0]  STBY_RST        = 5'h00;
  // frame geometry in serial clock periods, then channel and calibration word counts
  localparam logic [4:0]  ADDR_BITS       = 5'h08;
  localparam logic [4:0]  FRAME_BITS      = 5'h18;
  localparam int          NUM_CHAN        = 4;
  localparam int          NUM_CAL         = 7;

  // calibration set of one channel
  typedef struct packed {
    logic [7:0]      phase;
    logic [7:0]      int_gain;
    logic [9:0]      gain;
    logic [6:0][6:0] cal;
  } acr_chan_cal_t;

  // calibration set held by the master bank
  typedef struct packed {
    logic [3:0][8:0] offset;
    logic [4:0]      cm;
    logic [3:0]      rin;
  } acr_mst_cal_t;
endpackage

// file: pkg/acr_bank_if.sv
// acr_bank_if: write and read path from the serial front end to one channel bank.
// assumes a single clock; wr_en is a one-cycle pulse, rdata is combinational.
`timescale 1ns/1ps
interface acr_bank_if;
  logic        wr_en;
  logic [6:0]  waddr;
  logic [15:0] wdata;
  logic [6:0]  raddr;
  logic [15:0] rdata;
  modport bank (input wr_en, input waddr, input wdata, input raddr, output rdata);
  modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
endinterface

// file: src/acr_chan_bank.sv
// acr_chan_bank: one channel register bank, source override and standby.
// assumes writes arrive already routed by channel selection.
`timescale 1ns/1ps
module acr_chan_bank (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // register path
  acr_bank_if.bank                   bus,
  // factory calibration and delivered values
  input  wire acr_pkg::acr_chan_cal_t factory_cal,
  output acr_pkg::acr_chan_cal_t     delivered_cal,
  output logic                       power_down_ctl
);
  import acr_pkg::*;

  typedef struct packed {
    logic [15:0]   ovr;
    acr_chan_cal_t user;
    logic [4:0]    stby;
  } acr_bank_state_t;

  acr_bank_state_t s_reg;
  acr_bank_state_t s_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // register writes
  always_comb begin
    s_next = s_reg;
    if (bus.wr_en) begin
      if (bus.waddr == ADDR_SRC_OVR) begin
        s_next.ovr = bus.wdata & CH_OVR_MASK;
      end
      if (bus.waddr == ADDR_GAIN) begin
        s_next.user.gain = bus.wdata[9:0];
      end
      if (bus.waddr == ADDR_INT_GAIN) begin
        s_next.user.int_gain = bus.wdata[7:0];
      end
      if (bus.waddr == ADDR_PHASE) begin
        s_next.user.phase = bus.wdata[7:0];
      end
      if (bus.waddr == ADDR_STANDBY) begin
        s_next.stby = bus.wdata[4:0];
      end
      for (int k = 0; k < NUM_CAL; k++) begin
        if (bus.waddr == ADDR_CAL1 + 7'(k)) begin
          s_next.user.cal[k] = bus.wdata[6:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg               <= '0;
      s_reg.ovr           <= CH_OVR_RST;
      s_reg.user.gain     <= GAIN_RST;
      s_reg.user.int_gain <= INT_GAIN_RST;
      s_reg.user.phase    <= PHASE_RST;
      s_reg.user.cal      <= {NUM_CAL{CAL_RST}};
      s_reg.stby          <= STBY_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign delivered_cal.phase    = s_reg.ovr[COVR_PHASE] ? s_reg.user.phase : factory_cal.phase;
  assign delivered_cal.int_gain = s_reg.ovr[COVR_INT_GAIN] ? s_reg.user.int_gain
                                                           : factory_cal.int_gain;
  assign delivered_cal.gain     = s_reg.ovr[COVR_GAIN] ? s_reg.user.gain : factory_cal.gain;
  assign delivered_cal.cal      = s_reg.ovr[COVR_CAL] ? s_reg.user.cal : factory_cal.cal;
  assign power_down_ctl         = s_reg.stby[0];

  // read mux; stored values and delivered mirrors are separate addresses
  always_comb begin
    bus.rdata = 16'h0000;
    case (bus.raddr)
      ADDR_SRC_OVR:     bus.rdata = s_reg.ovr;
      ADDR_GAIN:        bus.rdata = {6'h00, s_reg.user.gain};
      ADDR_INT_GAIN:    bus.rdata = {8'h00, s_reg.user.int_gain};
      ADDR_PHASE:       bus.rdata = {8'h00, s_reg.user.phase};
      ADDR_STANDBY:     bus.rdata = {11'h000, s_reg.stby};
      ADDR_GAIN_RO:     bus.rdata = {6'h00, delivered_cal.gain};
      ADDR_INT_GAIN_RO: bus.rdata = {8'h00, delivered_cal.int_gain};
      ADDR_PHASE_RO:    bus.rdata = {8'h00, delivered_cal.phase};
      default:          bus.rdata = 16'h0000;
    endcase
    for (int k = 0; k < NUM_CAL; k++) begin
      if (bus.raddr == ADDR_CAL1 + 7'(k)) begin
        bus.rdata = {9'h000, s_reg.user.cal[k]};
      end
      if (bus.raddr == ADDR_CAL1_RO + 7'(k)) begin
        bus.rdata = {9'h000, delivered_cal.cal[k]};
      end
    end
  end

  AST_OVR_FIXED_ZERO: assert property ((s_reg.ovr & ~CH_OVR_MASK) == 16'h0000)
    else $error("channel override holds a fixed-zero bit");
  AST_PHASE_USER: assert property (
    bus.wr_en && bus.waddr == ADDR_SRC_OVR && bus.wdata[COVR_PHASE]
    |=> s_reg.ovr[COVR_PHASE] && delivered_cal.phase == s_reg.user.phase)
    else $error("phase not taken from user register after override");
  AST_GAIN_FACTORY: assert property (
    bus.wr_en && bus.waddr == ADDR_SRC_OVR && !bus.wdata[COVR_GAIN]
    |=> !s_reg.ovr[COVR_GAIN] && delivered_cal.gain == factory_cal.gain)
    else $error("gain left factory source without its override bit");
  AST_STANDBY_WRITE: assert property (
    bus.wr_en && bus.waddr == ADDR_STANDBY |=> power_down_ctl == $past(bus.wdata[0]))
    else $error("power down does not follow standby write");
endmodule // acr_chan_bank

// file: src/acr_top.sv
// acr_top: serial configuration port with master and per-channel bank routing.
// assumes serial pins are synchronous to clk and slower than clk/2.
//
// Functional notes
// - selection codes pick channel, all, or master
// - master bank never readable over serial port
// - single channel write updates master and channel
// - master selection writes master copy only
// - all selection writes master and four channels
// - standby per selected channel, one powers down
// - master override bits choose offset, common-mode, impedance
// - channel override bits choose phase, gains, calibrations
// - override bits clear at reset
// - each parameter source chosen independently
// - impedance override then write delivers user value
// - offset override then writes deliver user values
// - channel phase override affects that channel only
// - mirror reads delivered value, plain reads stored
`timescale 1ns/1ps
module acr_top (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  // serial port
  input  wire logic                                   sclk,
  input  wire logic                                   spi_cs_n,
  input  wire logic                                   mosi,
  output logic                                        miso,
  // factory values
  input  wire acr_pkg::acr_mst_cal_t                  factory_mst,
  input  wire acr_pkg::acr_chan_cal_t [3:0]           factory_chan,
  // values delivered to the cores
  output acr_pkg::acr_mst_cal_t                       core_mst_cal,
  output acr_pkg::acr_chan_cal_t [3:0]                core_chan_cal,
  output logic [3:0]                                  power_down_ctl
);
  import acr_pkg::*;

  typedef struct packed {
    logic            sclk_q;
    logic [4:0]      cnt;
    logic [22:0]     rx;
    logic            rd;
    logic [6:0]      raddr;
    logic [15:0]     tx;
    logic            miso;
    logic            wr;
    logic [6:0]      waddr;
    logic [15:0]     wdata;
    logic [2:0]      chan_sel;
    logic [2:0]      mst_ovr;
    acr_mst_cal_t    user;
  } acr_top_state_t;

  acr_top_state_t s_reg;
  acr_top_state_t s_next;
  logic           sclk_rise;
  logic           sclk_fall;
  logic [3:0]     bank_wr;
  logic [15:0]    bank_rdata [NUM_CHAN];
  logic [15:0]    rd_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  assign sclk_rise = sclk & ~s_reg.sclk_q;
  assign sclk_fall = ~sclk & s_reg.sclk_q;
  assign miso      = s_reg.miso;

  // master contents never shifted out
  // reads only reach a channel bank when exactly one is selected
  always_comb begin
    rd_data = 16'h0000;
    if (s_reg.chan_sel < SEL_ALL) begin
      rd_data = bank_rdata[s_reg.chan_sel[1:0]];
    end
  end

  always_comb begin
    bank_wr = 4'h0;
    if (s_reg.wr) begin
      if (s_reg.chan_sel == SEL_ALL) begin
        bank_wr = 4'hF;
      end else if (s_reg.chan_sel < SEL_ALL) begin
        bank_wr = 4'h1 << s_reg.chan_sel[1:0];
      end
    end
  end

  // frame shifter and master bank
  always_comb begin
    s_next        = s_reg;
    s_next.wr     = 1'b0;
    s_next.sclk_q = sclk;
    if (spi_cs_n) begin
      // output forced low while deselected, never floated
      s_next.cnt  = 5'h00;
      s_next.rd   = 1'b0;
      s_next.miso = 1'b0;
    end else begin
      if (sclk_rise && s_reg.cnt < FRAME_BITS) begin
        s_next.rx  = {s_reg.rx[21:0], mosi};
        s_next.cnt = s_reg.cnt + 5'h01;
        if (s_reg.cnt == ADDR_BITS - 5'h01) begin
          s_next.rd    = ~s_reg.rx[6];
          s_next.raddr = {s_reg.rx[5:0], mosi};
        end
        if (s_reg.cnt == FRAME_BITS - 5'h01 && s_reg.rx[22]) begin
          s_next.wr    = 1'b1;
          s_next.waddr = s_reg.rx[21:15];
          s_next.wdata = {s_reg.rx[14:0], mosi};
        end
      end
      // data leaves on falling edges so the master samples it on rising ones
      if (sclk_fall && s_reg.rd && s_reg.cnt >= ADDR_BITS && s_reg.cnt < FRAME_BITS) begin
        if (s_reg.cnt == ADDR_BITS) begin
          s_next.miso = rd_data[15];
          s_next.tx   = {rd_data[14:0], 1'b0};
        end else begin
          s_next.miso = s_reg.tx[15];
          s_next.tx   = {s_reg.tx[14:0], 1'b0};
        end
      end
    end
    // master copy takes every write, whatever the selection
    if (s_reg.wr) begin
      case (s_reg.waddr)
        ADDR_CHAN_SEL: s_next.chan_sel = s_reg.wdata[2:0];
        ADDR_SRC_OVR:  s_next.mst_ovr = s_reg.wdata[2:0];
        ADDR_CM:       s_next.user.cm = s_reg.wdata[4:0];
        ADDR_RIN:      s_next.user.rin = s_reg.wdata[3:0];
        default:       s_next.mst_ovr = s_reg.mst_ovr;
      endcase
      for (int k = 0; k < NUM_CHAN; k++) begin
        if (s_reg.waddr == ADDR_OFS_A + 7'(k)) begin
          s_next.user.offset[k] = s_reg.wdata[8:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg             <= '0;
      s_reg.chan_sel    <= CHAN_SEL_RST;
      s_reg.mst_ovr     <= MST_OVR_RST;
      s_reg.user.offset <= {NUM_CHAN{OFS_RST}};
      s_reg.user.cm     <= CM_RST;
      s_reg.user.rin    <= RIN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign core_mst_cal.offset = s_reg.mst_ovr[MOVR_OFS] ? s_reg.user.offset
                                                       : factory_mst.offset;
  assign core_mst_cal.cm     = s_reg.mst_ovr[MOVR_CM] ? s_reg.user.cm : factory_mst.cm;
  assign core_mst_cal.rin    = s_reg.mst_ovr[MOVR_RIN] ? s_reg.user.rin : factory_mst.rin;

  // one bank per channel
  // phase override stays inside the selected bank
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    acr_bank_if bus_if ();
    assign bus_if.wr_en = bank_wr[g];
    assign bus_if.waddr = s_reg.waddr;
    assign bus_if.wdata = s_reg.wdata;
    assign bus_if.raddr = s_reg.raddr;
    assign bank_rdata[g] = bus_if.rdata;
    acr_chan_bank u_bank (
      .clk           (clk),
      .resetn        (resetn),
      .bus           (bus_if),
      .factory_cal   (factory_chan[g]),
      .delivered_cal (core_chan_cal[g]),
      .power_down_ctl(power_down_ctl[g])
    );
  end

  AST_MASTER_NO_READ: assert property (s_reg.chan_sel[2] |-> !s_reg.miso)
    else $error("data driven out while master or all banks selected");
  AST_ROUTE_ONE: assert property (
    s_reg.wr && s_reg.chan_sel < SEL_ALL |-> bank_wr == (4'h1 << s_reg.chan_sel[1:0]))
    else $error("single channel write reached wrong banks");
  AST_ROUTE_MASTER: assert property (s_reg.wr && s_reg.chan_sel == SEL_MASTER |-> bank_wr == 4'h0)
    else $error("master-only write reached a channel bank");
  AST_ROUTE_ALL: assert property (s_reg.wr && s_reg.chan_sel == SEL_ALL |-> bank_wr == 4'hF)
    else $error("broadcast write missed a channel bank");
  AST_MST_OVR_WRITE: assert property (
    s_reg.wr && s_reg.waddr == ADDR_SRC_OVR |=> s_reg.mst_ovr == $past(s_reg.wdata[2:0]))
    else $error("master override copy not updated");
  AST_RIN_DELIVER: assert property (
    s_reg.wr && s_reg.waddr == ADDR_RIN && s_reg.mst_ovr[MOVR_RIN]
    |=> core_mst_cal.rin == $past(s_reg.wdata[3:0]))
    else $error("user impedance not delivered");
  AST_WRITE_PULSE: assert property (s_reg.wr |=> !s_reg.wr)
    else $error("write strobe longer than one cycle");
endmodule // acr_top

// file: tb/acr_spi_master.sv
// acr_spi_master: behavioural serial master facing the routing bank.
// assumes clk-paced edges; sclk idles low and stands still between frames.
`timescale 1ns/1ps
module acr_spi_master (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      spi_cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [15:0] rd_data;

  // idle pins at time zero
  initial begin
    sclk = 1'b0;
    spi_cs_n = 1'b1;
    mosi = 1'b0;
    rd_data = 16'h0000;
  end

  // one frame msb first; nbits under 24 aborts it, slow stretches low phase
  // direction bit leads
  task automatic xfer(input logic [23:0] frame, input int nbits, input int slow);
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      mosi <= frame[23-i];
      sclk <= 1'b0;
      repeat (3 + slow) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      // miso moved after the fall, so it is settled by now
      @(negedge clk);
      if (i >= 8) rd_data = {rd_data[14:0], miso};
    end
    @(posedge clk);
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    spi_cs_n <= 1'b1;
    mosi <= ~mosi; // released line must not look like stale data
    repeat (3) @(posedge clk);
  endtask
endmodule // acr_spi_master

// file: tb/tb.sv
// tb: self-checking bench for the channel routing register bank.
// assumes only acr_top pins; the serial master model owns the port.
`timescale 1ns/1ps
module tb;
  import acr_pkg::*;
  typedef enum int {K_RD, K_PD, K_PH, K_GN, K_OFS, K_CM, K_RIN, K_IG, K_CAL} acr_kind_t;
  typedef struct {acr_kind_t kind; int idx; logic [15:0] exp;} acr_note_t;

  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                sclk, spi_cs_n, mosi, miso;
  acr_mst_cal_t        factory_mst, core_mst_cal;
  acr_chan_cal_t [3:0] factory_chan, core_chan_cal;
  logic [3:0]          power_down_ctl;
  logic [15:0]         lfsr_reg = 16'h001C;
  acr_note_t           notes[$];
  int                  miscompares = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  // reference model of what the bank should hold
  logic [2:0]          sel, ovr_m;
  logic [15:0]         ovr_ch[4];
  logic [7:0]          u_ph[4];
  logic [8:0]          u_ofs[4];
  logic [3:0]          u_rin, pd;

  acr_top uut (.clk(clk), .resetn(resetn), .sclk(sclk), .spi_cs_n(spi_cs_n), .mosi(mosi),
    .miso(miso), .factory_mst(factory_mst), .factory_chan(factory_chan),
    .core_mst_cal(core_mst_cal), .core_chan_cal(core_chan_cal),
    .power_down_ctl(power_down_ctl));
  acr_spi_master u_master (.clk(clk), .sclk(sclk), .spi_cs_n(spi_cs_n), .mosi(mosi),
    .miso(miso));

  always #5 clk = ~clk;

  // hang guard, well above the roughly ten thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction

  function automatic logic [15:0] probe(input acr_kind_t k, input int i);
    case (k)
      K_RD:    return u_master.rd_data;
      K_PD:    return {12'h000, power_down_ctl};
      K_PH:    return {8'h00, core_chan_cal[i].phase};
      K_GN:    return {6'h00, core_chan_cal[i].gain};
      K_IG:    return {8'h00, core_chan_cal[i].int_gain};
      K_CAL:   return {9'h000, core_chan_cal[i / 8].cal[i % 8]};
      K_OFS:   return {7'h00, core_mst_cal.offset[i]};
      K_CM:    return {11'h000, core_mst_cal.cm};
      default: return {12'h000, core_mst_cal.rin};
    endcase
  endfunction

  // watcher: takes the oldest notes off once outputs have settled
  always @(negedge clk) begin
    acr_note_t   n;
    logic [15:0] act;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      act = probe(n.kind, n.idx);
      total_checks++;
      if (act !== n.exp) begin
        miscompares++;
        $display("CHECK FAILED t=%0t exp=%h act=%h", $time, n.exp, act);
      end
    end
  end

  task automatic model_reset();
    sel = CHAN_SEL_RST;
    ovr_m = MST_OVR_RST;
    u_rin = RIN_RST;
    pd = 4'h0;
    for (int c = 0; c < 4; c++) begin
      ovr_ch[c] = CH_OVR_RST;
      u_ph[c] = PHASE_RST;
      u_ofs[c] = OFS_RST;
    end
  endtask

  // write frame, then route it through the model like the bank should
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_master.xfer({1'b1, a, d}, 24, 0);
    if (a == ADDR_CHAN_SEL) sel = d[2:0];
    if (a == ADDR_SRC_OVR) ovr_m = d[2:0];
    if (a == ADDR_RIN) u_rin = d[3:0];
    if (a >= ADDR_OFS_A && a < ADDR_CM) u_ofs[a - ADDR_OFS_A] = d[8:0];
    for (int c = 0; c < 4; c++) begin
      if (sel == SEL_ALL || sel == c) begin
        if (a == ADDR_SRC_OVR) ovr_ch[c] = d & CH_OVR_MASK;
        if (a == ADDR_PHASE) u_ph[c] = d[7:0];
        if (a == ADDR_STANDBY) pd[c] = d[0];
      end
    end
  endtask

  // read frame with a stretched low phase, result noted for the watcher
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    u_master.xfer({1'b0, a, 16'h0000}, 24, 1);
    notes.push_back('{K_RD, 0, e});
  endtask

  task automatic check_all();
    for (int c = 0; c < 4; c++) begin
      notes.push_back('{K_PH, c, 16'(ovr_ch[c][COVR_PHASE] ? u_ph[c] : factory_chan[c].phase)});
      notes.push_back('{K_GN, c, 16'(ovr_ch[c][COVR_GAIN] ? GAIN_RST : factory_chan[c].gain)});
      notes.push_back('{K_IG, c, 16'(ovr_ch[c][COVR_INT_GAIN] ? INT_GAIN_RST
                                                             : factory_chan[c].int_gain)});
      // user calibration words are never written, so an override shows their reset value
      for (int k = 0; k < NUM_CAL; k++) begin
        notes.push_back('{K_CAL, 8 * c + k, 16'(ovr_ch[c][COVR_CAL] ? CAL_RST
                                                                   : factory_chan[c].cal[k])});
      end
      notes.push_back('{K_OFS, c, 16'(ovr_m[MOVR_OFS] ? u_ofs[c] : factory_mst.offset[c])});
    end
    notes.push_back('{K_CM, 0, 16'(ovr_m[MOVR_CM] ? CM_RST : factory_mst.cm)});
    notes.push_back('{K_RIN, 0, 16'(ovr_m[MOVR_RIN] ? u_rin : factory_mst.rin)});
    notes.push_back('{K_PD, 0, 16'(pd)});
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    factory_mst = acr_mst_cal_t'(45'({rnd(), rnd(), rnd()}));
    for (int c = 0; c < 4; c++) begin
      factory_chan[c] = acr_chan_cal_t'(75'({rnd(), rnd(), rnd(), rnd(), rnd()}));
    end
    model_reset();
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    check_all();
    // channel by channel override; last one writes every bit
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CHAN_SEL, 16'(c));
      wr(ADDR_SRC_OVR, (c == 3) ? 16'hFFFF : 16'h01D0);
      wr(ADDR_PHASE, rnd() & 16'h00FF);
      check_all();
      rd(ADDR_SRC_OVR, 16'h01D0);
      rd(ADDR_PHASE_RO, 16'(u_ph[c]));
    end
    wr(ADDR_CHAN_SEL, 16'h0007);
    wr(ADDR_SRC_OVR, 16'h0007);
    check_all();
    rd(ADDR_SRC_OVR, 16'h0000);
    wr(ADDR_SRC_OVR, 16'h0004);
    wr(ADDR_RIN, rnd() & 16'h000F);
    check_all();
    wr(ADDR_SRC_OVR, 16'h0005);
    for (int c = 0; c < 4; c++) wr(7'(ADDR_OFS_A + c), rnd() & 16'h01FF);
    check_all();
    wr(ADDR_CHAN_SEL, 16'h0004);
    wr(ADDR_SRC_OVR, 16'h0000);
    check_all();
    rd(ADDR_PHASE, 16'h0000);
    wr(ADDR_CHAN_SEL, 16'h0001);
    wr(ADDR_SRC_OVR, 16'h0010);
    wr(ADDR_PHASE, rnd() & 16'h00FF);
    check_all();
    rd(ADDR_PHASE_RO, 16'(u_ph[1]));
    rd(ADDR_GAIN_RO, 16'(factory_chan[1].gain));
    rd(ADDR_GAIN, 16'(GAIN_RST));
    rd(7'h7F, 16'h0000);
    wr(7'h7E, 16'hFFFF);
    // aborted frame must leave everything as it was
    u_master.xfer({1'b1, ADDR_SRC_OVR, 16'h0000}, 16, 0);
    check_all();
    // undefined selection code reaches no channel bank and reads nothing
    wr(ADDR_CHAN_SEL, 16'h0005);
    wr(ADDR_PHASE, rnd() & 16'h00FF);
    check_all();
    rd(ADDR_SRC_OVR, 16'h0000);
    wr(ADDR_CHAN_SEL, 16'h0004);
    wr(ADDR_SRC_OVR, 16'h01D7);
    wr(ADDR_STANDBY, 16'h0001);
    check_all();
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CHAN_SEL, 16'(c));
      wr(ADDR_STANDBY, 16'h0000);
      check_all();
    end
    wr(ADDR_CHAN_SEL, 16'h0004);
    wr(ADDR_STANDBY, 16'h0001);
    check_all();
    // second reset in mid-run clears overrides and standby
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    model_reset();
    check_all();
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule // tb
